// ---- asu_pkg.sv ----
// package: constants, states and carriers of the serial unit
package asu_pkg;
    localparam int unsigned TICKS_PER_BIT = 16;
    localparam logic [3:0]  START_SAMPLE  = 4'h7;
    localparam logic [3:0]  BIT_LAST_TICK = 4'hf;
    localparam logic [3:0]  BITS_BASE     = 4'h8;
    localparam logic        TX_EMPTY_RST  = 1'b1;
    localparam logic        TX_END_RST    = 1'b1;
    localparam logic        ID_WAIT_RST   = 1'b0;
    localparam logic        LINE_MARK     = 1'b1;

    typedef enum logic [1:0] {
        ASU_RX_IDLE  = 2'b00,
        ASU_RX_START = 2'b01,
        ASU_RX_BITS  = 2'b10
    } asu_rx_st_t;

    typedef enum logic {
        ASU_TX_IDLE = 1'b0,
        ASU_TX_RUN  = 1'b1
    } asu_tx_st_t;

    typedef struct packed {
        logic overrun;
        logic framing;
        logic parity;
    } asu_err_t;

    typedef struct packed {
        logic tx_empty;
        logic tx_end;
        logic rx_full;
    } asu_stat_t;
endpackage : asu_pkg

// ---- asu_serial_unit.sv ----
// serial unit with multiprocessor id format, request lines and tx fifo
`timescale 1ns/1ps

// ****************************************
// transmit fifo
// ****************************************
module asu_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rp_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            if (pop) rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : asu_fifo

// ****************************************
// serial unit top
// ****************************************
module asu_serial_unit #(
    parameter int DIV   = 4,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic          clock_i,
    input  wire logic          rst_b_i,
    // control bits
    input  wire logic          tx_en_i,
    input  wire logic          rx_en_i,
    input  wire logic          mp_mode_i,
    input  wire logic          parity_en_i,
    input  wire logic          parity_odd_i,
    input  wire logic          tx_empty_irq_en_i,
    input  wire logic          tx_end_irq_en_i,
    input  wire logic          rx_irq_en_i,
    input  wire logic          id_wait_set_i,
    input  wire asu_pkg::asu_err_t err_clr_i,
    // holding register write
    input  wire logic          tx_hold_wr_i,
    input  wire logic [8:0]    tx_hold_data_i,
    // streaming transmit input
    input  wire logic          tx_in_valid_i,
    output logic               tx_in_ready_o,
    input  wire logic [8:0]    tx_in_data_i,
    // receive data register
    input  wire logic          rx_data_rd_i,
    output logic [7:0]         rx_data_o,
    output logic               rx_mp_bit_o,
    // status
    output asu_pkg::asu_stat_t stat_o,
    output asu_pkg::asu_err_t  err_o,
    output logic               id_wait_en_o,
    output logic               serial_in_level_o,
    // requests
    output logic               tx_empty_req_o,
    output logic               tx_end_req_o,
    output logic               rx_full_req_o,
    output logic               rx_error_req_o,
    // serial line
    input  wire logic          serial_in_pin_i,
    output logic               tx_pin_o
);
    // ****************************************
    // basic clock at sixteen times bit rate
    // ****************************************
    logic [15:0] div_q;
    logic        tick;
    assign tick = (div_q == 16'(DIV-1));
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) div_q <= '0;
        else div_q <= tick ? '0 : div_q + 16'h0001;
    end

    function automatic logic [3:0] frame_bits(input logic mp, input logic pe);
        return asu_pkg::BITS_BASE + 4'((mp | pe) ? 1 : 0);
    endfunction

    // ****************************************
    // transmit side
    // ****************************************
    asu_pkg::asu_tx_st_t tx_st_q;
    logic [8:0]  tx_hold_q;
    logic [10:0] tx_shift_q;
    logic [3:0]  tx_left_q;
    logic [3:0]  tx_tk_q;
    logic        tx_empty_q;
    logic        tx_end_q;
    logic        fifo_valid;
    logic        fifo_pop;
    logic [8:0]  fifo_data;
    logic        tx_bit_end;
    logic        tx_load;
    logic        tx_extra;

    asu_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
        .clock_i    (clock_i),
        .rst_b_i    (rst_b_i),
        .in_valid_i (tx_in_valid_i),
        .in_ready_o (tx_in_ready_o),
        .in_data_i  (tx_in_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o (fifo_data)
    );

    // fifo refills holding only when empty, so it never overwrites
    assign fifo_pop   = tx_empty_q & !tx_hold_wr_i & !tx_load;
    assign tx_bit_end = tick & (tx_tk_q == asu_pkg::BIT_LAST_TICK);
    assign tx_load    = tx_en_i & !tx_empty_q &
                        ((tx_st_q == asu_pkg::ASU_TX_IDLE) |
                         (tx_bit_end & (tx_left_q == 4'h1)));
    assign tx_extra   = mp_mode_i ? tx_hold_q[8]
                                  : (^tx_hold_q[7:0]) ^ parity_odd_i;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) tx_hold_q <= '0;
        else if (tx_hold_wr_i) tx_hold_q <= tx_hold_data_i;
        else if (fifo_valid & fifo_pop) tx_hold_q <= fifo_data;
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) tx_empty_q <= asu_pkg::TX_EMPTY_RST;
        else if (tx_hold_wr_i | (fifo_valid & fifo_pop)) tx_empty_q <= 1'b0;
        else if (tx_load) tx_empty_q <= 1'b1;
    end

    // next frame or end with mark
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_st_q    <= asu_pkg::ASU_TX_IDLE;
            tx_shift_q <= '1;
            tx_left_q  <= '0;
            tx_tk_q    <= '0;
            tx_end_q   <= asu_pkg::TX_END_RST;
        end else if (!tx_en_i) begin
            tx_st_q    <= asu_pkg::ASU_TX_IDLE;
            tx_shift_q <= '1;
            tx_end_q   <= 1'b1;
        end else if (tx_load) begin
            tx_st_q   <= asu_pkg::ASU_TX_RUN;
            tx_tk_q   <= '0;
            tx_end_q  <= 1'b0;
            tx_left_q <= frame_bits(mp_mode_i, parity_en_i) + 4'h2;
            tx_shift_q <= (mp_mode_i | parity_en_i)
                        ? {1'b1, tx_extra, tx_hold_q[7:0], 1'b0}
                        : {2'b11, tx_hold_q[7:0], 1'b0};
        end else if (tx_st_q == asu_pkg::ASU_TX_RUN && tick) begin
            tx_tk_q <= tx_tk_q + 4'h1;
            if (tx_bit_end) begin
                tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                tx_left_q  <= tx_left_q - 4'h1;
                if (tx_left_q == 4'h1) begin
                    tx_st_q  <= asu_pkg::ASU_TX_IDLE;
                    tx_end_q <= 1'b1;
                end
            end
        end
    end

    assign tx_pin_o = (tx_st_q == asu_pkg::ASU_TX_RUN) ? tx_shift_q[0]
                                                       : asu_pkg::LINE_MARK;

    // ****************************************
    // receive side
    // ****************************************
    asu_pkg::asu_rx_st_t rx_st_q;
    logic [8:0] rx_sh_q;
    logic [3:0] rx_idx_q;
    logic [3:0] rx_tk_q;
    logic       rx_prev_q;
    logic [7:0] rx_data_q;
    logic       rx_mpb_q;
    logic       rx_full_q;
    logic       id_wait_q;
    asu_pkg::asu_err_t err_q;
    logic [3:0] nb;
    logic       rx_samp;
    logic       rx_done;
    logic       discard;
    logic       par_bad;
    logic       blocked;

    assign nb      = frame_bits(mp_mode_i, parity_en_i);
    assign rx_samp = tick & (rx_tk_q == asu_pkg::BIT_LAST_TICK);
    assign rx_done = (rx_st_q == asu_pkg::ASU_RX_BITS) & rx_samp & (rx_idx_q == nb);
    assign discard = mp_mode_i & id_wait_q & !rx_sh_q[8];
    assign par_bad = parity_en_i & !mp_mode_i &
                     ((^rx_sh_q[7:0]) ^ parity_odd_i ^ rx_sh_q[8]);
    assign blocked = err_q.overrun | err_q.framing | err_q.parity;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_st_q   <= asu_pkg::ASU_RX_IDLE;
            rx_sh_q   <= '0;
            rx_idx_q  <= '0;
            rx_tk_q   <= '0;
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= serial_in_pin_i;
            unique case (rx_st_q)
                asu_pkg::ASU_RX_IDLE: begin
                    rx_tk_q  <= '0;
                    rx_idx_q <= '0;
                    if (rx_en_i & !blocked & rx_prev_q & !serial_in_pin_i)
                        rx_st_q <= asu_pkg::ASU_RX_START;
                end
                asu_pkg::ASU_RX_START: begin
                    if (tick) rx_tk_q <= rx_tk_q + 4'h1;
                    if (tick && rx_tk_q == asu_pkg::START_SAMPLE) begin
                        rx_tk_q <= '0;
                        rx_st_q <= serial_in_pin_i ? asu_pkg::ASU_RX_IDLE
                                                   : asu_pkg::ASU_RX_BITS;
                    end
                end
                asu_pkg::ASU_RX_BITS: begin
                    if (tick) rx_tk_q <= rx_tk_q + 4'h1;
                    if (rx_samp) begin
                        if (rx_idx_q < nb) rx_sh_q[rx_idx_q] <= serial_in_pin_i;
                        rx_idx_q <= rx_idx_q + 4'h1;
                        if (rx_idx_q == nb) rx_st_q <= asu_pkg::ASU_RX_IDLE;
                    end
                end
                default: rx_st_q <= asu_pkg::ASU_RX_IDLE;
            endcase
            if (!rx_en_i) rx_st_q <= asu_pkg::ASU_RX_IDLE;
        end
    end

    // overrun keeps old data; framing stores
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_data_q <= '0;
            rx_mpb_q  <= 1'b0;
        end else if (rx_done & !discard & !rx_full_q) begin
            rx_data_q <= rx_sh_q[7:0];
            rx_mpb_q  <= mp_mode_i & rx_sh_q[8];
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) rx_full_q <= 1'b0;
        else if (rx_done & !discard & !rx_full_q) rx_full_q <= 1'b1;
        else if (rx_data_rd_i) rx_full_q <= 1'b0;
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) err_q <= '0;
        else begin
            if (rx_done & !discard & rx_full_q) err_q.overrun <= 1'b1;
            else if (err_clr_i.overrun) err_q.overrun <= 1'b0;
            if (rx_done & !discard & !serial_in_pin_i) err_q.framing <= 1'b1;
            else if (err_clr_i.framing) err_q.framing <= 1'b0;
            if (rx_done & !discard & par_bad) err_q.parity <= 1'b1;
            else if (err_clr_i.parity) err_q.parity <= 1'b0;
        end
    end

    // id frame ends the wait; id kept for compare unless rx_full_q is already set
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) id_wait_q <= asu_pkg::ID_WAIT_RST;
        else if (id_wait_set_i) id_wait_q <= 1'b1;
        else if (rx_done & mp_mode_i & rx_sh_q[8]) id_wait_q <= 1'b0;
    end

    // ****************************************
    // outputs and requests
    // ****************************************
    assign rx_data_o         = rx_data_q;
    assign rx_mp_bit_o       = rx_mpb_q;
    assign err_o             = err_q;
    assign stat_o            = '{tx_empty: tx_empty_q, tx_end: tx_end_q,
                                 rx_full: rx_full_q};
    assign id_wait_en_o      = id_wait_q;
    assign serial_in_level_o = serial_in_pin_i;
    // four request lines; gated by enables
    assign tx_empty_req_o = tx_en_i & tx_empty_irq_en_i & tx_empty_q;
    assign tx_end_req_o   = tx_en_i & tx_end_irq_en_i & tx_end_q;
    assign rx_full_req_o  = rx_en_i & rx_irq_en_i & rx_full_q;
    assign rx_error_req_o = rx_en_i & rx_irq_en_i & blocked;

    // ****************************************
    // checks
    // ****************************************
    AST_WR_CLEARS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        tx_hold_wr_i |=> !tx_empty_q) else $error("write did not clear empty");
    AST_MARK_AT_END: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        tx_end_q |-> tx_pin_o) else $error("line not mark after end");
    AST_LOAD_SETS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        tx_load & !tx_hold_wr_i |=> tx_empty_q && !tx_end_q && !tx_pin_o)
        else $error("load did not start frame");
    AST_RD_CLEARS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        rx_data_rd_i & !rx_done |=> !rx_full_q) else $error("read kept full");
    AST_OVR_KEEP: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        rx_done & !discard & rx_full_q |=> err_q.overrun && $stable(rx_data_q))
        else $error("overrun lost or data moved");
    AST_DISCARD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        rx_done & discard |=> $stable(rx_data_q) && !$rose(rx_full_q) && !$rose(blocked))
        else $error("data frame not skipped");
    AST_BLOCKED: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        blocked |=> rx_st_q == asu_pkg::ASU_RX_IDLE) else $error("rx ran with error");
    AST_ID_END: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        rx_done & mp_mode_i & rx_sh_q[8] & !rx_full_q & !id_wait_set_i
        |=> !id_wait_q && rx_full_q) else $error("id frame not taken");
    AST_NO_PARITY: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        mp_mode_i & rx_done |=> !$rose(err_q.parity)) else $error("parity in mp mode");
    AST_FRAMING: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        rx_done & !discard & !rx_full_q & !serial_in_pin_i
        |=> err_q.framing ##0 rx_full_q) else $error("framing not flagged");
endmodule : asu_serial_unit

// ---- asu_line_peer.sv ----
// line peer: frame sender on line_o and frame capture on tx_line_i
`timescale 1ns/1ps

// ****************************************
// line peer
// ****************************************
module asu_line_peer #(
    parameter int BT = 16
) (
    // clock
    input  wire logic clock_i,
    // serial line
    input  wire logic tx_line_i,
    output logic      line_o
);
    logic [9:0] cap_q [$];
    logic [9:0] bits;

    initial begin
        line_o = asu_pkg::LINE_MARK;
    end

    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask : tick

    task automatic send_frame(input logic [7:0] d, input logic mp, input logic stp);
        logic [10:0] f;
        f = {stp, mp, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_o = f[i];
            repeat (BT) tick();
        end
        line_o = asu_pkg::LINE_MARK;
    endtask : send_frame

    task automatic set_line(input logic v);
        line_o = v;
    endtask : set_line

    initial begin
        forever begin
            tick();
            if (tx_line_i === 1'b0) begin
                repeat (BT / 2) tick();
                for (int i = 0; i < 10; i++) begin
                    repeat (BT) tick();
                    bits[i] = tx_line_i;
                end
                cap_q.push_back(bits);
            end
        end
    end
endmodule : asu_line_peer

// ---- asu_serial_unit_tb.sv ----
// testbench of the serial unit: transmit, fifo, id wait, errors, requests
`timescale 1ns/1ps
`define CHK(nm, ex, gt) chk(nm, 12'(ex), 12'(gt))

module asu_serial_unit_tb;
    localparam int BT    = 16;
    localparam int DEPTH = 4;
    logic              clock_i;
    logic              rst_b_i;
    logic              tx_en, rx_en, mp_mode, par_en, par_odd, txe_ie, txd_ie, rx_ie, id_set;
    logic              hold_wr, in_valid, rd, rx_mp, id_wait, in_level, in_ready;
    logic              txe_req, txd_req, rxf_req, rxe_req, rx_pin, tx_pin;
    logic [8:0]        hold_d;
    logic [8:0]        in_data;
    logic [7:0]        rx_data;
    asu_pkg::asu_err_t  err_clr;
    asu_pkg::asu_err_t  err;
    asu_pkg::asu_stat_t stat;
    int                bad_count;
    int                comparisons;
    int                cycles;
    int                n;

    asu_serial_unit #(.DIV(1), .DEPTH(DEPTH)) dut (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .tx_en_i(tx_en), .rx_en_i(rx_en),
        .mp_mode_i(mp_mode), .parity_en_i(par_en), .parity_odd_i(par_odd),
        .tx_empty_irq_en_i(txe_ie), .tx_end_irq_en_i(txd_ie), .rx_irq_en_i(rx_ie),
        .id_wait_set_i(id_set), .err_clr_i(err_clr), .tx_hold_wr_i(hold_wr),
        .tx_hold_data_i(hold_d), .tx_in_valid_i(in_valid), .tx_in_ready_o(in_ready),
        .tx_in_data_i(in_data), .rx_data_rd_i(rd), .rx_data_o(rx_data), .rx_mp_bit_o(rx_mp),
        .stat_o(stat), .err_o(err), .id_wait_en_o(id_wait), .serial_in_level_o(in_level),
        .tx_empty_req_o(txe_req), .tx_end_req_o(txd_req), .rx_full_req_o(rxf_req),
        .rx_error_req_o(rxe_req), .serial_in_pin_i(rx_pin), .tx_pin_o(tx_pin)
    );

    asu_line_peer #(.BT(BT)) peer (.clock_i(clock_i), .tx_line_i(tx_pin), .line_o(rx_pin));

    always #5 clock_i = ~clock_i;

    task automatic summarize();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    always @(posedge clock_i) begin
        cycles++;
        if (cycles > 30000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [11:0] ex, input logic [11:0] gt);
        comparisons++;
        if (gt !== ex) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt);
        end
    endtask : chk

    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask : tick

    task automatic wr_hold(input logic [8:0] d);
        hold_wr = 1'b1;
        hold_d = d;
        tick();
        hold_wr = 1'b0;
    endtask : wr_hold

    task automatic pulse_rd();
        rd = 1'b1;
        tick();
        rd = 1'b0;
    endtask : pulse_rd

    task automatic wait_cap(input int k);
        for (int i = 0; i < 2500 && peer.cap_q.size() < k; i++) begin
            tick();
        end
        repeat (BT) tick();
    endtask : wait_cap

    initial begin
        clock_i = 1'b0;
        rst_b_i = 1'b0;
        {tx_en, rx_en, mp_mode, par_en, par_odd, txe_ie, txd_ie, rx_ie, id_set} = 9'h000;
        {hold_wr, in_valid, rd} = 3'h0;
        err_clr = 3'h0;
        hold_d = 9'h000;
        in_data = 9'h000;
        bad_count = 0;
        comparisons = 0;
        cycles = 0;
        repeat (3) @(posedge clock_i);
        #1;
        rst_b_i = 1'b1;
        `CHK("reset flags", 7'h60, {stat, err, id_wait});
        `CHK("reset line", 1'b1, tx_pin);
        {txe_ie, txd_ie, rx_ie} = 3'h7;
        tick();
        `CHK("gated reqs", 2'b00, {txe_req, txd_req});
        {tx_en, rx_en, mp_mode, par_en, par_odd} = 5'h1f;
        tick();
        `CHK("early reqs", 2'b11, {txe_req, txd_req});
        wr_hold(9'h1a5);
        `CHK("empty on write", 1'b0, stat.tx_empty);
        tick();
        `CHK("load", 2'b10, {stat.tx_empty, stat.tx_end});
        `CHK("reqs sending", 2'b10, {txe_req, txd_req});
        wr_hold(9'h05a);
        tick();
        wr_hold(9'h096);
        wait_cap(2);
        `CHK("id frame sent", 10'h3a5, peer.cap_q[0]);
        `CHK("overwrite sent", 10'h296, peer.cap_q[1]);
        `CHK("end mark", 3'b111, {stat.tx_end, txd_req, tx_pin});
        repeat (BT * 12) tick();
        `CHK("no extra frame", 2, peer.cap_q.size());
        n = 0;
        in_valid = 1'b1;
        in_data = 9'h0c0;
        for (int k = 0; k < 20; k++) begin
            if (in_ready === 1'b1) begin
                n++;
            end
            tick();
            in_data = 9'h0c0 + 9'(n);
        end
        `CHK("fifo refuses", 1'b0, in_ready);
        in_valid = 1'b0;
        `CHK("fifo depth", 1'b1, n > DEPTH);
        wait_cap(2 + n);
        for (int k = 0; k < n; k++) begin
            `CHK("fifo frame", 10'h2c0 + 10'(k), peer.cap_q[2 + k]);
        end
        `CHK("drained", 3'b111, {in_ready, stat.tx_end, tx_pin});
        {txe_ie, txd_ie} = 2'b00;
        wr_hold(9'h0f0);
        `CHK("quiet after write", 2'b00, {txe_req, txd_req});
        {txe_ie, txd_ie} = 2'b11;
        tick();
        `CHK("reqs after write", 2'b10, {txe_req, txd_req});
        wait_cap(3 + n);
        `CHK("late enable frame", 10'h2f0, peer.cap_q[2 + n]);
        id_set = 1'b1;
        tick();
        id_set = 1'b0;
        `CHK("id wait on", 1'b1, id_wait);
        peer.send_frame(8'h11, 1'b0, 1'b1);
        `CHK("data skipped", 1'b0, stat.rx_full);
        peer.send_frame(8'h3c, 1'b1, 1'b1);
        `CHK("id stored", 11'h53c, {stat.rx_full, id_wait, rx_mp, rx_data});
        `CHK("rx reqs", 5'h10, {rxf_req, rxe_req, err});
        pulse_rd();
        `CHK("read clears", 2'b00, {stat.rx_full, rxf_req});
        peer.send_frame(8'h77, 1'b0, 1'b1);
        `CHK("data taken", 9'h177, {stat.rx_full, rx_data});
        pulse_rd();
        id_set = 1'b1;
        tick();
        id_set = 1'b0;
        peer.send_frame(8'h55, 1'b0, 1'b1);
        `CHK("mismatch skip", 2'b01, {stat.rx_full, id_wait});
        peer.send_frame(8'h3c, 1'b1, 1'b1);
        peer.send_frame(8'h99, 1'b0, 1'b1);
        `CHK("overrun mp kept", 1'b1, rx_mp);
        `CHK("overrun", 12'hc3c, {stat.rx_full, err, rx_data});
        `CHK("error req", 2'b11, {rxf_req, rxe_req});
        rx_ie = 1'b0;
        tick();
        `CHK("rx gated", 2'b00, {rxf_req, rxe_req});
        rx_ie = 1'b1;
        pulse_rd();
        peer.send_frame(8'h44, 1'b0, 1'b1);
        `CHK("blocked", 1'b0, stat.rx_full);
        err_clr = 3'h4;
        tick();
        err_clr = 3'h0;
        peer.send_frame(8'he1, 1'b0, 1'b0);
        `CHK("framing", 12'hae1, {stat.rx_full, err, rx_data});
        peer.set_line(1'b0);
        tick();
        `CHK("break level", 1'b0, in_level);
        peer.set_line(1'b1);
        tick();
        `CHK("level back", 1'b1, in_level);
        pulse_rd();
        err_clr = 3'h2;
        tick();
        err_clr = 3'h0;
        `CHK("cleared", 5'h00, {rxe_req, stat.rx_full, err});
        mp_mode = 1'b0;
        peer.send_frame(8'h01, 1'b1, 1'b1);
        `CHK("parity error", 12'h901, {stat.rx_full, err, rx_data});
        `CHK("parity req", 3'b110, {rxf_req, rxe_req, rx_mp});
        summarize();
    end
endmodule : asu_serial_unit_tb
